// ===== design/dcps_pkg.sv
// constants, types and command decode for the cke power state block
// assumes one command slot per rising edge of the link clock
package dcps_pkg;

  localparam int NBANK = 8;
  // cycles of link clock a burst of eight occupies the data bus
  localparam logic [3:0] BURST_CK = 4'h4;
  // busy windows in link clock cycles, plain defaults
  localparam logic [7:0] REF_BUSY_CK = 8'h20;
  localparam logic [7:0] MRD_BUSY_CK = 8'h04;
  localparam logic [7:0] XS_BUSY_CK = 8'h10;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_ACT = 5'h02,
    ST_APD = 5'h04,
    ST_PPD = 5'h08,
    ST_SREF = 5'h10
  } dcps_state_t;

  typedef enum logic [2:0] {
    OP_NOP = 3'h0,
    OP_ACT = 3'h1,
    OP_RD = 3'h2,
    OP_WR = 3'h3,
    OP_PRE = 3'h4,
    OP_REF = 3'h5,
    OP_MRS = 3'h6,
    OP_ZQ = 3'h7
  } dcps_op_t;

  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic a10;
    logic [2:0] ba;
  } dcps_cmd_t;

  typedef struct packed {
    logic ce_m;
    logic ce_s;
    logic cke_prev;
    dcps_state_t st;
    logic [NBANK-1:0] open;
    logic [NBANK-1:0] pend_close;
    logic [3:0] burst;
    logic [7:0] busy;
    logic cmd_valid;
    dcps_op_t op;
    logic odt_on;
    logic sref_run;
    logic bad_tgl;
  } dcps_link_t;

  typedef struct packed {
    logic apd_m;
    logic apd_s;
    logic ppd_m;
    logic ppd_s;
    logic sr_m;
    logic sr_s;
    logic bad_m;
    logic bad_s;
    logic bad_p;
    logic illegal;
  } dcps_core_t;

  localparam dcps_link_t LINK_RST = '{st: ST_IDLE, op: OP_NOP, default: '0};
  localparam dcps_core_t CORE_RST = '0;

  // deselect decodes exactly as no-operation
  function automatic dcps_op_t decode_op(input dcps_cmd_t c);
    dcps_op_t r;
    r = OP_NOP;
    if (!c.cs_n) begin
      unique case ({c.ras_n, c.cas_n, c.we_n})
        3'h7: r = OP_NOP;
        3'h3: r = OP_ACT;
        3'h5: r = OP_RD;
        3'h4: r = OP_WR;
        3'h2: r = OP_PRE;
        3'h1: r = OP_REF;
        3'h0: r = OP_MRS;
        3'h6: r = OP_ZQ;
      endcase
    end
    return r;
  endfunction

endpackage

// ===== design/dcps_top.sv
// cke driven power-down and self-refresh state keeping of a dram die
// assumes cke, cmd and odt are launched by the controller on the link clock ck
`timescale 1ns/10ps
module dcps_top (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic ck,
  input wire logic cke,
  input wire dcps_pkg::dcps_cmd_t cmd,
  input wire logic odt,
  output logic cmd_valid,
  output dcps_pkg::dcps_op_t cmd_op,
  output logic odt_term,
  output logic pd_active,
  output logic pd_precharge,
  output logic self_refresh,
  output logic illegal
);
  import dcps_pkg::*;

  dcps_link_t l_q;
  dcps_link_t l_d;
  dcps_core_t c_q;
  dcps_core_t c_d;
  dcps_op_t op_now;
  logic idle_now;
  logic [NBANK-1:0] remain;

  assign op_now = decode_op(cmd);
  // state before the edge must be idle with cke high and nothing pending
  assign idle_now = (l_q.st == ST_IDLE) && l_q.cke_prev && (l_q.open == '0) &&
                    (l_q.burst == 4'h0) && (l_q.busy == 8'h00);

  // link side: one step per rising edge of ck
  always_comb begin
    l_d = l_q;
    remain = '0;
    l_d.ce_m = clk_en;
    l_d.ce_s = l_q.ce_m;
    if (l_q.ce_s) begin
      l_d.cke_prev = cke;
      l_d.cmd_valid = 1'b0;
      // a running burst is never cut short by nop or deselect
      if (l_q.burst != 4'h0) begin
        l_d.burst = 4'(l_q.burst - 4'h1);
        if (l_q.burst == 4'h1) begin
          l_d.open = l_q.open & ~l_q.pend_close;
          l_d.pend_close = '0;
        end
      end
      if (l_q.busy != 8'h00 && l_q.st != ST_SREF) begin
        l_d.busy = 8'(l_q.busy - 8'h01);
      end
      remain = l_q.open & ~l_q.pend_close;
      unique case (l_q.st)
        ST_APD, ST_PPD, ST_SREF: begin
          // command pins are don't-care while cke stays low; odt still drives odt_on in power-down
          if (cke) begin
            if (op_now == OP_NOP) begin
              // first edge with cke high suffices, no earlier edge is needed
              if (l_q.st == ST_SREF) begin
                l_d.st = ST_IDLE;
                l_d.busy = XS_BUSY_CK;
              end else begin
                l_d.st = (l_q.open != '0) ? ST_ACT : ST_IDLE;
              end
            end else begin
              l_d.bad_tgl = ~l_q.bad_tgl;
            end
          end
        end
        ST_IDLE, ST_ACT: begin
          if (l_q.cke_prev && !cke) begin
            if (op_now == OP_NOP) begin
              l_d.st = (remain != '0) ? ST_APD : ST_PPD;
            end else if (op_now == OP_REF && idle_now) begin
              l_d.st = ST_SREF;
            end else begin
              l_d.bad_tgl = ~l_q.bad_tgl;
            end
          end else if (cke) begin
            l_d.cmd_valid = (op_now != OP_NOP);
            l_d.op = op_now;
            unique case (op_now)
              OP_ACT: l_d.open[cmd.ba] = 1'b1;
              OP_RD, OP_WR: begin
                l_d.burst = BURST_CK;
                if (cmd.a10) begin
                  l_d.pend_close[cmd.ba] = 1'b1;
                end
              end
              OP_PRE: begin
                if (cmd.a10) begin
                  l_d.open = '0;
                end else begin
                  l_d.open[cmd.ba] = 1'b0;
                end
              end
              OP_REF: l_d.busy = REF_BUSY_CK;
              OP_MRS, OP_ZQ: l_d.busy = MRD_BUSY_CK;
              OP_NOP: l_d.op = l_q.op;
            endcase
            l_d.st = (l_d.open != '0) ? ST_ACT : ST_IDLE;
          end
        end
      endcase
      // internal refresh only in self-refresh, never in power-down
      l_d.sref_run = (l_d.st == ST_SREF);
      l_d.odt_on = odt && (l_d.st != ST_SREF);
    end
  end

  always_ff @(posedge ck or negedge nrst) begin
    if (!nrst) begin
      l_q <= LINK_RST;
    end else begin
      l_q <= l_d;
    end
  end

  // core side: state levels and the illegal toggle cross on two flops
  always_comb begin
    c_d = c_q;
    if (clk_en) begin
      c_d.apd_m = (l_q.st == ST_APD);
      c_d.apd_s = c_q.apd_m;
      c_d.ppd_m = (l_q.st == ST_PPD);
      c_d.ppd_s = c_q.ppd_m;
      c_d.sr_m = l_q.sref_run;
      c_d.sr_s = c_q.sr_m;
      c_d.bad_m = l_q.bad_tgl;
      c_d.bad_s = c_q.bad_m;
      c_d.bad_p = c_q.bad_s;
      c_d.illegal = c_q.bad_s ^ c_q.bad_p;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      c_q <= CORE_RST;
    end else begin
      c_q <= c_d;
    end
  end

  assign cmd_valid = l_q.cmd_valid;
  assign cmd_op = l_q.op;
  assign odt_term = l_q.odt_on;
  assign pd_active = c_q.apd_s;
  assign pd_precharge = c_q.ppd_s;
  assign self_refresh = c_q.sr_s;
  assign illegal = c_q.illegal;

  property p_apd_entry;
    @(posedge ck) disable iff (!nrst)
      (l_q.ce_s && l_q.st == ST_ACT && l_q.burst == 4'h0 && l_q.cke_prev && !cke &&
       op_now == OP_NOP) |=> (l_q.st == ST_APD);
  endproperty
  a_apd_entry: assert property (p_apd_entry) else $error("no active power-down entry");

  property p_ppd_after_burst;
    @(posedge ck) disable iff (!nrst)
      (l_q.ce_s && l_q.burst != 4'h0 && l_q.cke_prev && !cke && op_now == OP_NOP &&
       (l_q.open & ~l_q.pend_close) == '0 && (l_q.st == ST_ACT || l_q.st == ST_IDLE))
      |=> (l_q.st == ST_PPD);
  endproperty
  a_ppd_after_burst: assert property (p_ppd_after_burst) else $error("wrong power-down kind");

  property p_pins_ignored;
    @(posedge ck) disable iff (!nrst)
      (l_q.ce_s && (l_q.st == ST_APD || l_q.st == ST_PPD || l_q.st == ST_SREF) && !cke)
      // only a bank whose auto-close burst ends may still change
      |=> (!l_q.cmd_valid && l_q.op == $past(l_q.op) &&
           (l_q.open | $past(l_q.pend_close)) == ($past(l_q.open) | $past(l_q.pend_close)));
  endproperty
  a_pins_ignored: assert property (p_pins_ignored) else $error("command taken in low power");

  property p_no_ref_in_pd;
    @(posedge ck) disable iff (!nrst)
      (l_q.st == ST_APD || l_q.st == ST_PPD) |-> (!l_q.sref_run && !c_q.sr_m);
  endproperty
  a_no_ref_in_pd: assert property (p_no_ref_in_pd) else $error("refresh ran in power-down");

  property p_odt_off_sr;
    @(posedge ck) disable iff (!nrst)
      (l_q.st == ST_SREF) |-> !l_q.odt_on;
  endproperty
  a_odt_off_sr: assert property (p_odt_off_sr) else $error("termination on in self-refresh");

  property p_sr_hold;
    @(posedge ck) disable iff (!nrst)
      (l_q.ce_s && l_q.st == ST_SREF && !cke) ##1 (l_q.ce_s && !cke) |=> (l_q.st == ST_SREF);
  endproperty
  a_sr_hold: assert property (p_sr_hold) else $error("left self-refresh with cke low");

  property p_burst_runs;
    @(posedge ck) disable iff (!nrst)
      (l_q.ce_s && l_q.burst > 4'h1 && op_now == OP_NOP)
      |=> (l_q.burst == 4'($past(l_q.burst) - 4'h1));
  endproperty
  a_burst_runs: assert property (p_burst_runs) else $error("burst cut by nop");

  property p_sr_from_idle;
    @(posedge ck) disable iff (!nrst)
      $rose(l_q.st == ST_SREF) |-> ($past(l_q.open) == '0 && $past(l_q.burst) == 4'h0 &&
                                    $past(l_q.busy) == 8'h00 && !$past(cke));
  endproperty
  a_sr_from_idle: assert property (p_sr_from_idle) else $error("self-refresh from non-idle");

  property p_exit;
    @(posedge ck) disable iff (!nrst)
      (l_q.ce_s && l_q.st == ST_SREF && cke && op_now == OP_NOP)
      |=> (l_q.st == ST_IDLE && l_q.busy == XS_BUSY_CK) ##1 (l_q.st != ST_SREF);
  endproperty
  a_exit: assert property (p_exit) else $error("self-refresh exit missed");

  property p_sr_seen;
    @(posedge mclk) disable iff (!nrst)
      (clk_en && l_q.sref_run) [*4] |-> self_refresh;
  endproperty
  a_sr_seen: assert property (p_sr_seen) else $error("self-refresh level not crossed");

  c_apd: cover property (@(posedge ck) disable iff (!nrst) l_q.st == ST_APD ##1 l_q.st == ST_ACT);
  c_sref: cover property (@(posedge ck) disable iff (!nrst) l_q.st == ST_SREF ##1 l_q.st == ST_IDLE);
  c_ppd_burst: cover property (@(posedge ck) disable iff (!nrst)
    l_q.burst != 4'h0 ##1 l_q.st == ST_PPD);
  c_bad: cover property (@(posedge mclk) disable iff (!nrst) illegal);

endmodule

// ===== testbench/dcps_ctrl_model.sv
// controller model that drives the link pins of the cke power state block
// assumes the bench calls send once per request and keeps the request order legal
`timescale 1ns/10ps
module dcps_ctrl_model (
  output logic ck,
  output logic cke,
  output dcps_pkg::dcps_cmd_t cmd,
  output logic odt
);
  import dcps_pkg::*;
  localparam dcps_cmd_t NOP_CMD = 8'h70;
  // ras, cas, we levels indexed by op
  localparam logic [2:0] RCW [8] = '{3'h7, 3'h3, 3'h5, 3'h4, 3'h2, 3'h1, 3'h0, 3'h6};
  logic own;
  initial begin
    ck = 1'h0;
    #7;
    forever #32 ck = ~ck;
  end
  initial begin
    cke = 1'h1;
    odt = 1'h0;
    own = 1'h0;
    cmd = NOP_CMD;
  end
  // only nop between requests; while cke is low the pins wander like a floating bus
  always @(negedge ck) begin
    if (!own) begin
      cmd <= cke ? NOP_CMD : ~cmd;
    end
  end
  // cke level held until the next request, which can come on the very next clock
  task automatic send(input logic ke, input logic des, input dcps_op_t op, input logic a10,
      input logic [2:0] ba, input logic t);
    own = 1'h1;
    @(negedge ck);
    cke <= ke;
    cmd <= {des, RCW[op], a10, ba};
    odt <= t;
    @(posedge ck);
    own = 1'h0;
  endtask
endmodule

// ===== testbench/dcps_top_tb.sv
// self-checking bench for the cke power state block
// assumes the controller model owns the link pins and the bench owns mclk, nrst, clk_en
`timescale 1ns/10ps
module dcps_top_tb;
  import dcps_pkg::*;
  typedef struct packed {
    logic [3:0] in;
    dcps_op_t op;
    logic [2:0] ba;
    logic v;
    dcps_op_t xop;
    logic [3:0] ex;
  } dcps_row_t;
  logic mclk, nrst, clk_en, ck, cke, odt, ill_seen;
  dcps_cmd_t cmd;
  logic cmd_valid, odt_term, pd_active, pd_precharge, self_refresh, illegal;
  dcps_op_t cmd_op;
  dcps_row_t rows [17];
  int n_fail, compares;
  dcps_ctrl_model u_dcps_ctrl_model (.ck(ck), .cke(cke), .cmd(cmd), .odt(odt));
  dcps_top u_dcps_top (.mclk(mclk), .nrst(nrst), .clk_en(clk_en), .ck(ck), .cke(cke),
    .cmd(cmd), .odt(odt), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .odt_term(odt_term),
    .pd_active(pd_active), .pd_precharge(pd_precharge), .self_refresh(self_refresh),
    .illegal(illegal));
  initial begin
    mclk = 1'h0;
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (illegal === 1'h1) ill_seen = 1'h1;
  end
  task automatic stop_test;
    if (n_fail == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_op(input dcps_op_t got, input dcps_op_t exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // in = {cke, deselect, a10, odt}; ex = {active pd, precharge pd, self-refresh, illegal}
  task automatic run_row(input dcps_row_t r);
    ill_seen = 1'h0;
    u_dcps_ctrl_model.send(r.in[3], r.in[2], r.op, r.in[1], r.ba, r.in[0]);
    #1;
    chk_bit(cmd_valid, r.v);
    chk_op(cmd_op, r.xop);
    chk_bit(odt_term, r.in[0] & ~r.ex[1]);
    repeat (6) @(negedge mclk);
    chk_bit(pd_active, r.ex[3]);
    chk_bit(pd_precharge, r.ex[2]);
    chk_bit(self_refresh, r.ex[1]);
    chk_bit(ill_seen, r.ex[0]);
  endtask
  initial begin
    #20000;
    n_fail++;
    stop_test();
  end
  initial begin
    nrst = 1'h0;
    clk_en = 1'h1;
    ill_seen = 1'h0;
    n_fail = 0;
    compares = 0;
    rows[0] = '{4'h9, OP_ACT, 3'h1, 1'h1, OP_ACT, 4'h0};
    rows[1] = '{4'h1, OP_NOP, 3'h0, 1'h0, OP_ACT, 4'h8};
    rows[2] = '{4'h1, OP_RD, 3'h0, 1'h0, OP_ACT, 4'h8};
    rows[3] = '{4'hD, OP_NOP, 3'h0, 1'h0, OP_ACT, 4'h0};
    rows[4] = '{4'hA, OP_RD, 3'h1, 1'h1, OP_RD, 4'h0};
    rows[5] = '{4'h0, OP_NOP, 3'h0, 1'h0, OP_RD, 4'h4};
    rows[6] = '{4'h8, OP_NOP, 3'h0, 1'h0, OP_RD, 4'h0};
    rows[7] = '{4'h1, OP_REF, 3'h0, 1'h0, OP_RD, 4'h2};
    rows[8] = '{4'h9, OP_NOP, 3'h0, 1'h0, OP_RD, 4'h0};
    rows[9] = '{4'h1, OP_REF, 3'h0, 1'h0, OP_RD, 4'h1};
    rows[10] = '{4'h8, OP_ACT, 3'h2, 1'h1, OP_ACT, 4'h0};
    rows[11] = '{4'h8, OP_WR, 3'h2, 1'h1, OP_WR, 4'h0};
    rows[12] = '{4'hA, OP_PRE, 3'h0, 1'h1, OP_PRE, 4'h0};
    rows[13] = '{4'h8, OP_MRS, 3'h0, 1'h1, OP_MRS, 4'h0};
    rows[14] = '{4'h8, OP_ZQ, 3'h0, 1'h1, OP_ZQ, 4'h0};
    rows[15] = '{4'h8, OP_REF, 3'h0, 1'h1, OP_REF, 4'h0};
    rows[16] = '{4'h0, OP_REF, 3'h0, 1'h0, OP_REF, 4'h1};
    repeat (4) @(negedge mclk);
    nrst = 1'h1;
    repeat (4) @(posedge ck);
    for (int i = 0; i < 17; i++) begin
      run_row(rows[i]);
    end
    // power-down entered on the edge right after a read with auto-close
    run_row(rows[10]);
    u_dcps_ctrl_model.send(1'h1, 1'h0, OP_RD, 1'h1, 3'h2, 1'h0);
    run_row(rows[5]);
    run_row(rows[6]);
    // clock enable low freezes the link after its two sync edges
    @(negedge mclk);
    clk_en = 1'h0;
    repeat (3) @(posedge ck);
    u_dcps_ctrl_model.send(1'h1, 1'h0, OP_ACT, 1'h0, 3'h1, 1'h0);
    #1;
    chk_bit(cmd_valid, 1'h0);
    chk_op(cmd_op, OP_RD);
    @(negedge mclk);
    clk_en = 1'h1;
    // reset in mid-run clears every output of both domains
    @(negedge mclk);
    nrst = 1'h0;
    u_dcps_ctrl_model.send(1'h1, 1'h0, OP_NOP, 1'h0, 3'h0, 1'h0);
    repeat (4) @(negedge mclk);
    chk_bit(|{cmd_valid, cmd_op, odt_term, pd_active, pd_precharge, self_refresh, illegal},
      1'h0);
    nrst = 1'h1;
    repeat (4) @(posedge ck);
    run_row(rows[0]);
    stop_test();
  end
endmodule
